/* inc/ttc_pkg.sv */
// Package for the triple timer/counter unit: register map, field positions,
// machine-cycle phases and the packed state of the unit.
// Assumes one 200 MHz clock and an AHB-Lite master with single word transfers.
package ttc_pkg;

   // Clock and machine-cycle timing
   localparam int CLK_MHZ = 200;
   localparam int CLKS_PER_MCYCLE = 4;
   localparam logic [1:0] PH_C3 = 2'h2;
   localparam logic [1:0] PH_C4 = 2'h3;
   localparam logic [1:0] STD_DIV_LAST = 2'h2; // 3 machine cycles = 12 clocks

   // Word offsets (byte address = 4 x index)
   localparam logic [5:0] IDX_TIMER_CONTROL = 6'h00;
   localparam logic [5:0] IDX_TIMER_MODE = 6'h01;
   localparam logic [5:0] IDX_CLOCK_CONTROL = 6'h02;
   localparam logic [5:0] IDX_CNT_A_LOW = 6'h03;
   localparam logic [5:0] IDX_CNT_A_HIGH = 6'h04;
   localparam logic [5:0] IDX_CNT_B_LOW = 6'h05;
   localparam logic [5:0] IDX_CNT_B_HIGH = 6'h06;
   localparam logic [5:0] IDX_CNT_C_CONTROL = 6'h07;
   localparam logic [5:0] IDX_CNT_C_MODE = 6'h08;
   localparam logic [5:0] IDX_CNT_C_LOW = 6'h09;
   localparam logic [5:0] IDX_CNT_C_HIGH = 6'h0A;
   localparam logic [5:0] IDX_CAPTURE_LOW = 6'h0B;
   localparam logic [5:0] IDX_CAPTURE_HIGH = 6'h0C;

   // timer_control_reg fields
   localparam int TC_RUN_A = 4;
   localparam int TC_OVF_A = 5;
   localparam int TC_RUN_B = 6;
   localparam int TC_OVF_B = 7;
   // timer_mode_reg fields (A in low nibble, B in high nibble)
   localparam int TM_MODE_A = 0;
   localparam int TM_FUNC_A = 2;
   localparam int TM_GATE_A = 3;
   localparam int TM_MODE_B = 4;
   localparam int TM_FUNC_B = 6;
   localparam int TM_GATE_B = 7;
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // clock_control_reg fields
   localparam int CK_TURBO_A = 3;
   localparam int CK_TURBO_B = 4;
   localparam int CK_TURBO_C = 5;
   // cnt_c_control_reg fields
   localparam int CC_CAP_SEL = 0;
   localparam int CC_SRC_SEL = 1;
   localparam int CC_RUN = 2;
   localparam int CC_EXT_EN = 3;
   localparam int CC_EXT_FLAG = 6;
   localparam int CC_OVF = 7;
   // cnt_c_mode_reg fields
   localparam int CM_AUTO_CLR = 3;

   // Sampled pin positions
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_C = 2;
   localparam int PIN_CAP = 3;

   localparam logic [7:0] REG_RST = 8'h00;

   typedef struct packed {
      logic [1:0] phase;
      logic [1:0] div3;
      logic [3:0] samp;
      logic [3:0] pend;
      logic [7:0] timer_control_reg;
      logic [7:0] timer_mode_reg;
      logic [7:0] clock_control_reg;
      logic [7:0] cnt_a_low;
      logic [7:0] cnt_a_high;
      logic [7:0] cnt_b_low;
      logic [7:0] cnt_b_high;
      logic [7:0] cnt_c_control_reg;
      logic [7:0] cnt_c_mode_reg;
      logic [7:0] cnt_c_low;
      logic [7:0] cnt_c_high;
      logic [7:0] capture_low;
      logic [7:0] capture_high;
      logic wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] rdata;
   } ttc_state_t;

endpackage

/* rtl/ttc_top.sv */
// Triple timer/counter unit: counters A and B (13-bit and split modes) and
// counter C (capture mode), with an AHB-Lite register slave.
// Assumes pins are synchronous to hclk and one master doing word transfers.
//
// Summary of operation
// - Timer function of A and B counts clock divided by twelve or four.
// - Count pins sampled at C4; high then low sample is a falling edge.
// - Counts update at C3; a detected edge counts in the next machine cycle.
// - Function select bit 2 for A, bit 6 for B: 0 clock, 1 pin.
// - A and B each have two mode select bits, four modes.
// - Reset clears turbo bits (divide by twelve); set bit gives divide by four.
// - Mode 0 is 13 bits: high byte plus low five bits, upper three ignored.
// - Low bit 4 falling steps high byte; 13-bit wrap sets overflow flag.
// - Counting needs run bit and either gate qualify 0 or gate pin 1.
// - Counter B in mode 3 freezes and holds its count.
// - A mode 3: low byte is 8-bit counter with A's controls and flag.
// - A mode 3: high byte counts clock, uses B run bit and B flag.
// - With A in mode 3, B runs without run bit or flag; mode 3 stops it.
// - C counts pin edges or divided clock by source select, while run is 1.
// - C in capture mode counts 16 bits; wrap sets overflow flag, requests interrupt.
// - Capture pin falling edge with enable copies C into capture registers, sets flag.
// - Auto-clear bit 3 of C mode register clears C after each capture.
// - A and B overflow flags set at C3 of the overflowing machine cycle.
// - Vectoring to a timer routine clears A or B overflow flag.
// - C overflow and external flags cleared only by software.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

module ttc_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // External pins
   input wire logic count_pin_a,
   input wire logic count_pin_b,
   input wire logic count_pin_c,
   input wire logic capture_pin,
   input wire logic gate_pin_a,
   input wire logic gate_pin_b,
   // Interrupt vector acknowledges, one-cycle pulses
   input wire logic vec_ack_a,
   input wire logic vec_ack_b,
   // Flag outputs
   output logic ovf_a,
   output logic ovf_b,
   output logic irq_c
);

   // All state lives in one packed struct, registered once per clock.
   // Limits: modes 1 and 2 of A and B, and the reload, baud-rate and
   // clock-out modes of C, are not built; in them the count holds.
   // A bus write to a count register wins over a step in the same cycle,
   // so software can load a running counter without a torn value.
   // Flags of A and B clear by acknowledge or software, C's by software only.
   ttc_pkg::ttc_state_t s;
   ttc_pkg::ttc_state_t next_s;

   // 13-bit step: {carry, high, low}; upper three low bits pass unchanged
   // Carry out of low bit 4 is what steps the high byte
   function automatic logic [16:0] inc13(input logic [7:0] hi, input logic [7:0] lo);
      logic [13:0] sum;
      sum = {1'b0, hi, lo[4:0]} + 14'h0001;
      return {sum[13], sum[12:5], lo[7:5], sum[4:0]};
   endfunction

   // 8-bit step: {carry, value}
   function automatic logic [8:0] inc8(input logic [7:0] v);
      logic [8:0] sum;
      sum = {1'b0, v} + 9'h001;
      return sum;
   endfunction

   // Time-base tick at C3: every machine cycle in turbo, else every third
   function automatic logic tbase(input logic turbo, input logic c3, input logic [1:0] dv);
      return c3 & (turbo | (dv == 2'h0));
   endfunction

   // Gate qualification of a counter's input
   // With gate qualify clear the pin is ignored
   function automatic logic gated(input logic run, input logic gate, input logic pin);
      return run & (~gate | pin);
   endfunction

   // Machine-cycle strobes and pin events
   logic c3;
   logic c4;
   logic [3:0] pins;
   logic [3:0] ev;

   // Time-base ticks
   logic tick_a;
   logic tick_b;
   logic tick_c;

   // Mode decode and qualified inputs
   logic a_split;
   logic [1:0] mode_a;
   logic [1:0] mode_b;
   logic en_a;
   logic en_b;
   logic in_a;
   logic in_b;
   logic in_c;

   // Flag set requests
   logic set_ovf_a;
   logic set_ovf_b;
   logic set_ovf_c;
   logic set_ext;

   // Adder results, carry on top
   logic [16:0] r13;
   logic [8:0] r8;
   logic [16:0] r16;

   // Bus decode
   logic addr_ok;
   logic [7:0] rd_byte;
   logic [7:0] wb;

   // Pin vector in the order of the pin positions
   assign pins = {capture_pin, count_pin_c, count_pin_b, count_pin_a};

   // Register read mux, shared by the address phase
   // Combinational, so the byte is ready when an address is taken
   always_comb begin
      unique case (haddr[7:2])
         ttc_pkg::IDX_TIMER_CONTROL: rd_byte = s.timer_control_reg;
         ttc_pkg::IDX_TIMER_MODE: rd_byte = s.timer_mode_reg;
         ttc_pkg::IDX_CLOCK_CONTROL: rd_byte = s.clock_control_reg;
         ttc_pkg::IDX_CNT_A_LOW: rd_byte = s.cnt_a_low;
         ttc_pkg::IDX_CNT_A_HIGH: rd_byte = s.cnt_a_high;
         ttc_pkg::IDX_CNT_B_LOW: rd_byte = s.cnt_b_low;
         ttc_pkg::IDX_CNT_B_HIGH: rd_byte = s.cnt_b_high;
         ttc_pkg::IDX_CNT_C_CONTROL: rd_byte = s.cnt_c_control_reg;
         ttc_pkg::IDX_CNT_C_MODE: rd_byte = s.cnt_c_mode_reg;
         ttc_pkg::IDX_CNT_C_LOW: rd_byte = s.cnt_c_low;
         ttc_pkg::IDX_CNT_C_HIGH: rd_byte = s.cnt_c_high;
         ttc_pkg::IDX_CAPTURE_LOW: rd_byte = s.capture_low;
         ttc_pkg::IDX_CAPTURE_HIGH: rd_byte = s.capture_high;
         default: rd_byte = 8'h00; // Unmapped words read as zero
      endcase
   end

   // Next-state logic of the whole unit
   always_comb begin
      next_s = s;
      c3 = (s.phase == ttc_pkg::PH_C3);
      c4 = (s.phase == ttc_pkg::PH_C4);
      set_ovf_a = 1'b0;
      set_ovf_b = 1'b0;
      set_ovf_c = 1'b0;
      set_ext = 1'b0;
      r13 = 17'h0_0000;
      r8 = 9'h000;
      r16 = 17'h0_0000;
      wb = hwdata[7:0];

      // Machine-cycle phase and divide-by-three of machine cycles
      // Phase zero is C1, free running from reset release
      next_s.phase = s.phase + 2'h1;
      if (c4) begin
         next_s.div3 = (s.div3 == ttc_pkg::STD_DIV_LAST) ? 2'h0 : s.div3 + 2'h1;
      end

      // Pins sampled once per machine cycle at C4
      // Samples clear at reset, so a pin low from reset gives no edge;
      // a pulse shorter than a machine cycle can slip between samples
      if (c4) begin
         next_s.samp = pins;
         next_s.pend = s.samp & ~pins; // High then low sample
      end
      // Edge from the previous machine cycle is applied at this C3
      // Events are strobes in the C3 cycle only
      ev = s.pend & {4{c3}};

      // Time bases, turbo bits choose 1/4 or 1/12
      // One shared divide-by-three keeps the time bases aligned
      tick_a = tbase(s.clock_control_reg[ttc_pkg::CK_TURBO_A], c3, s.div3);
      tick_b = tbase(s.clock_control_reg[ttc_pkg::CK_TURBO_B], c3, s.div3);
      tick_c = tbase(s.clock_control_reg[ttc_pkg::CK_TURBO_C], c3, s.div3);

      mode_a = s.timer_mode_reg[ttc_pkg::TM_MODE_A +: 2];
      mode_b = s.timer_mode_reg[ttc_pkg::TM_MODE_B +: 2];
      a_split = (mode_a == ttc_pkg::MODE_SPLIT);

      // Counted inputs: function select picks pin edge or time base
      // Gate pins taken as synchronous, no extra stage
      in_a = s.timer_mode_reg[ttc_pkg::TM_FUNC_A] ? ev[ttc_pkg::PIN_A] : tick_a;
      in_b = s.timer_mode_reg[ttc_pkg::TM_FUNC_B] ? ev[ttc_pkg::PIN_B] : tick_b;
      en_a = gated(s.timer_control_reg[ttc_pkg::TC_RUN_A],
                   s.timer_mode_reg[ttc_pkg::TM_GATE_A], gate_pin_a);
      // B loses its run bit while A is split
      en_b = gated(a_split | s.timer_control_reg[ttc_pkg::TC_RUN_B],
                   s.timer_mode_reg[ttc_pkg::TM_GATE_B], gate_pin_b);

      // Counter A; no step while disabled keeps value and flag
      // Modes 1 and 2 match neither branch, so the count holds
      if (mode_a == ttc_pkg::MODE_13BIT) begin
         if (en_a & in_a) begin
            r13 = inc13(s.cnt_a_high, s.cnt_a_low);
            {next_s.cnt_a_high, next_s.cnt_a_low} = r13[15:0];
            set_ovf_a = r13[16];
         end
      end else if (a_split) begin
         // Low byte with A's own controls
         // Its wrap sets A's flag, as in 13-bit mode
         if (en_a & in_a) begin
            r8 = inc8(s.cnt_a_low);
            next_s.cnt_a_low = r8[7:0];
            set_ovf_a = r8[8];
         end
         // High byte times clocks under B's run bit and flag
         // It ignores gate qualify and function select
         if (s.timer_control_reg[ttc_pkg::TC_RUN_B] & tick_a) begin
            r8 = inc8(s.cnt_a_high);
            next_s.cnt_a_high = r8[7:0];
            set_ovf_b = r8[8];
         end
      end

      // Counter B; mode 3 freezes it split A takes its flag
      // While A is split a wrap of B raises no flag
      if (mode_b == ttc_pkg::MODE_13BIT && en_b && in_b) begin
         r13 = inc13(s.cnt_b_high, s.cnt_b_low);
         {next_s.cnt_b_high, next_s.cnt_b_low} = r13[15:0];
         if (!a_split) begin
            set_ovf_b = r13[16];
         end
      end

      // Counter C in capture mode
      // Reload modes not built; with capture select clear C holds
      // The capture pin is only watched in capture mode
      in_c = s.cnt_c_control_reg[ttc_pkg::CC_SRC_SEL] ? ev[ttc_pkg::PIN_C] : tick_c;
      if (s.cnt_c_control_reg[ttc_pkg::CC_CAP_SEL]) begin
         if (s.cnt_c_control_reg[ttc_pkg::CC_RUN] & in_c) begin
            r16 = {1'b0, s.cnt_c_high, s.cnt_c_low} + 17'h0_0001;
            {next_s.cnt_c_high, next_s.cnt_c_low} = r16[15:0];
            set_ovf_c = r16[16];
         end
         // External capture of the value held this cycle
         // The copy takes the value before this cycle's step
         if (s.cnt_c_control_reg[ttc_pkg::CC_EXT_EN] & ev[ttc_pkg::PIN_CAP]) begin
            next_s.capture_low = s.cnt_c_low;
            next_s.capture_high = s.cnt_c_high;
            set_ext = 1'b1;
            if (s.cnt_c_mode_reg[ttc_pkg::CM_AUTO_CLR]) begin
               next_s.cnt_c_low = 8'h00;
               next_s.cnt_c_high = 8'h00;
            end
         end
      end

      // Bus write lands in the data phase; a count write overrides a step
      // Unmapped words are dropped without a bus error
      next_s.wr_pend = 1'b0;
      if (s.wr_pend) begin
         unique case (s.wr_idx)
            ttc_pkg::IDX_TIMER_CONTROL: next_s.timer_control_reg = wb;
            ttc_pkg::IDX_TIMER_MODE: next_s.timer_mode_reg = wb;
            ttc_pkg::IDX_CLOCK_CONTROL: next_s.clock_control_reg = wb;
            ttc_pkg::IDX_CNT_A_LOW: next_s.cnt_a_low = wb;
            ttc_pkg::IDX_CNT_A_HIGH: next_s.cnt_a_high = wb;
            ttc_pkg::IDX_CNT_B_LOW: next_s.cnt_b_low = wb;
            ttc_pkg::IDX_CNT_B_HIGH: next_s.cnt_b_high = wb;
            ttc_pkg::IDX_CNT_C_CONTROL: next_s.cnt_c_control_reg = wb;
            ttc_pkg::IDX_CNT_C_MODE: next_s.cnt_c_mode_reg = wb;
            ttc_pkg::IDX_CNT_C_LOW: next_s.cnt_c_low = wb;
            ttc_pkg::IDX_CNT_C_HIGH: next_s.cnt_c_high = wb;
            ttc_pkg::IDX_CAPTURE_LOW: next_s.capture_low = wb;
            ttc_pkg::IDX_CAPTURE_HIGH: next_s.capture_high = wb;
            default: next_s.wr_pend = 1'b0; // Unmapped write is dropped
         endcase
      end

      // Flags: acknowledge or software clears, hardware set wins
      // Sets come last, so no overflow is lost to a clear
      if (vec_ack_a) begin
         next_s.timer_control_reg[ttc_pkg::TC_OVF_A] = 1'b0;
      end
      if (vec_ack_b) begin
         next_s.timer_control_reg[ttc_pkg::TC_OVF_B] = 1'b0;
      end
      if (set_ovf_a) begin
         next_s.timer_control_reg[ttc_pkg::TC_OVF_A] = 1'b1;
      end
      if (set_ovf_b) begin
         next_s.timer_control_reg[ttc_pkg::TC_OVF_B] = 1'b1;
      end
      // C flags are never cleared here, only by a software write
      if (set_ovf_c) begin
         next_s.cnt_c_control_reg[ttc_pkg::CC_OVF] = 1'b1;
      end
      if (set_ext) begin
         next_s.cnt_c_control_reg[ttc_pkg::CC_EXT_FLAG] = 1'b1;
      end

      // AHB-Lite address phase; zero wait states, read data registered here
      // Size is not checked: every access is one word, low byte used
      // A write leaves zero in the read data register
      addr_ok = hsel & htrans[1] & hready;
      if (addr_ok) begin
         next_s.wr_pend = hwrite;
         next_s.wr_idx = haddr[7:2];
         next_s.rdata = hwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
   end

   // Single state register; turbo bits and all else clear at reset
   // Constants only in the reset branch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs
   // Handshake outputs constant, flags straight from state
   assign hreadyout = 1'b1; // Never stalls
   assign hresp = 1'b0; // Always OKAY
   assign hrdata = s.rdata;
   assign ovf_a = s.timer_control_reg[ttc_pkg::TC_OVF_A];
   assign ovf_b = s.timer_control_reg[ttc_pkg::TC_OVF_B];
   assign irq_c = s.cnt_c_control_reg[ttc_pkg::CC_OVF] |
                  s.cnt_c_control_reg[ttc_pkg::CC_EXT_FLAG];

endmodule // ttc_top

/* test/triple_timer_counter_unit_tb.sv */
// Self-checking bench for the timer unit over AHB-Lite and its pins.
// Assumes hready is the unit's own hreadyout (single slave).
`timescale 1ns/1ps

module triple_timer_counter_unit_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic vec_ack_a = 1'b0;
   logic vec_ack_b = 1'b0;
   logic hreadyout, hresp, ovf_a, ovf_b, irq_c;
   logic ca, cb, cc, cap, ga, gb;
   logic [31:0] hrdata;
   logic [7:0] rd, lo;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;

   always #2.5 hclk = ~hclk;

   ttc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .count_pin_a(ca),
      .count_pin_b(cb), .count_pin_c(cc), .capture_pin(cap), .gate_pin_a(ga),
      .gate_pin_b(gb), .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b), .ovf_a(ovf_a),
      .ovf_b(ovf_b), .irq_c(irq_c));
   ttc_pin_model u_pins (.clk(hclk), .count_pin_a(ca), .count_pin_b(cb),
      .count_pin_c(cc), .capture_pin(cap), .gate_pin_a(ga), .gate_pin_b(gb));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single transfer; the master waits for hready in both phases
   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   // Tick counts are known only to one count, since start and stop land on any phase
   function automatic logic in_rng(input int v, input int e);
      return (v >= e - 1) && (v <= e + 1);
   endfunction

   // Hang guard, well above the expected run length
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      void'($urandom(62344));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(ttc_pkg::IDX_CLOCK_CONTROL, 8'h00);
      rdchk(ttc_pkg::IDX_TIMER_MODE, 8'h00);
      rdchk(6'h3F, 8'h00);
      // Counter A 13-bit wrap from 1FFE in turbo, upper low bits kept
      wr(ttc_pkg::IDX_CNT_A_HIGH, 8'hFF);
      wr(ttc_pkg::IDX_CNT_A_LOW, 8'hFE);
      wr(ttc_pkg::IDX_CLOCK_CONTROL, 8'h08);
      wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h10);
      n = 0;
      while (ovf_a !== 1'b1 && n < 40) begin
         @(posedge hclk);
         n++;
      end
      chk(n < 10, 1'b1);
      wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h20);
      bus(1'b0, ttc_pkg::IDX_CNT_A_LOW, 8'h00);
      chk(rd[7:5], 3'h7);
      rdchk(ttc_pkg::IDX_CNT_A_HIGH, 8'h00);
      vec_ack_a <= 1'b1;
      @(posedge hclk);
      vec_ack_a <= 1'b0;
      @(posedge hclk);
      chk(ovf_a, 1'b0);
      // Divide by twelve, then by four, over 242 clocks of run
      for (int t = 0; t < 2; t++) begin
         wr(ttc_pkg::IDX_CNT_A_LOW, 8'h00);
         wr(ttc_pkg::IDX_CNT_A_HIGH, 8'h00);
         wr(ttc_pkg::IDX_CLOCK_CONTROL, t ? 8'h08 : 8'h00);
         wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h10);
         repeat (240) @(posedge hclk);
         wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h00);
         bus(1'b0, ttc_pkg::IDX_CNT_A_LOW, 8'h00);
         lo = rd;
         bus(1'b0, ttc_pkg::IDX_CNT_A_HIGH, 8'h00);
         chk(in_rng(int'({rd, lo[4:0]}), t ? 60 : 20), 1'b1);
      end
      // Counter B on pin edges, gated, then under A's split mode
      wr(ttc_pkg::IDX_TIMER_MODE, 8'h40);
      wr(ttc_pkg::IDX_CNT_B_LOW, 8'h00);
      wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h40);
      n = $urandom_range(8, 3);
      u_pins.edges(ttc_pkg::PIN_B, n, n[0]);
      rdchk(ttc_pkg::IDX_CNT_B_LOW, n[7:0]);
      wr(ttc_pkg::IDX_TIMER_MODE, 8'hC0);
      u_pins.set_gates(1'b1, 1'b0);
      u_pins.edges(ttc_pkg::PIN_B, 3, 1'b0);
      rdchk(ttc_pkg::IDX_CNT_B_LOW, n[7:0]);
      u_pins.set_gates(1'b1, 1'b1);
      u_pins.edges(ttc_pkg::PIN_B, 2, 1'b1);
      rdchk(ttc_pkg::IDX_CNT_B_LOW, 8'(n + 2));
      wr(ttc_pkg::IDX_TIMER_MODE, 8'h43);
      wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h00);
      u_pins.edges(ttc_pkg::PIN_B, 3, 1'b0);
      rdchk(ttc_pkg::IDX_CNT_B_LOW, 8'(n + 5));
      wr(ttc_pkg::IDX_TIMER_MODE, 8'h77);
      u_pins.edges(ttc_pkg::PIN_B, 2, 1'b0);
      rdchk(ttc_pkg::IDX_CNT_B_LOW, 8'(n + 5));
      wr(ttc_pkg::IDX_CNT_A_LOW, 8'hFE);
      wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h10);
      u_pins.edges(ttc_pkg::PIN_A, 3, 1'b0);
      rdchk(ttc_pkg::IDX_CNT_A_LOW, 8'h01);
      chk(ovf_a, 1'b1);
      wr(ttc_pkg::IDX_CNT_A_HIGH, 8'hFF);
      wr(ttc_pkg::IDX_TIMER_CONTROL, 8'h40);
      repeat (60) @(posedge hclk);
      chk(ovf_b, 1'b1);
      vec_ack_b <= 1'b1;
      @(posedge hclk);
      vec_ack_b <= 1'b0;
      @(posedge hclk);
      chk(ovf_b, 1'b0);
      // Counter C on pin edges: wrap, capture, then capture with auto-clear
      wr(ttc_pkg::IDX_CNT_C_LOW, 8'hFE);
      wr(ttc_pkg::IDX_CNT_C_HIGH, 8'hFF);
      wr(ttc_pkg::IDX_CNT_C_CONTROL, 8'h0F);
      u_pins.edges(ttc_pkg::PIN_C, 3, 1'b0);
      chk(irq_c, 1'b1);
      rdchk(ttc_pkg::IDX_CNT_C_LOW, 8'h01);
      u_pins.edges(ttc_pkg::PIN_CAP, 1, 1'b1);
      rdchk(ttc_pkg::IDX_CAPTURE_LOW, 8'h01);
      rdchk(ttc_pkg::IDX_CNT_C_CONTROL, 8'hCF);
      wr(ttc_pkg::IDX_CNT_C_MODE, 8'h08);
      u_pins.edges(ttc_pkg::PIN_C, 2, 1'b1);
      u_pins.edges(ttc_pkg::PIN_CAP, 1, 1'b0);
      rdchk(ttc_pkg::IDX_CAPTURE_LOW, 8'h03);
      rdchk(ttc_pkg::IDX_CNT_C_LOW, 8'h00);
      wr(ttc_pkg::IDX_CNT_C_CONTROL, 8'h00);
      @(posedge hclk);
      chk(irq_c, 1'b0);
      // Mid-run reset must drop the turbo bit set above
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(ttc_pkg::IDX_CLOCK_CONTROL, 8'h00);
      summarize();
   end
endmodule // triple_timer_counter_unit_tb

/* test/ttc_pin_model.sv */
// Far side of the timer unit: count, capture and gate pins.
// Assumes the caller enters its tasks just after a rising clock edge.
`timescale 1ns/1ps

module ttc_pin_model (
   // Clock
   input wire logic clk,
   // Pins toward the unit
   output logic count_pin_a,
   output logic count_pin_b,
   output logic count_pin_c,
   output logic capture_pin,
   output logic gate_pin_a,
   output logic gate_pin_b
);
   logic [3:0] pins = 4'hF; // Idle high so the first low is a clean edge

   assign {capture_pin, count_pin_c, count_pin_b, count_pin_a} = pins;
   initial begin
      gate_pin_a = 1'b0;
      gate_pin_b = 1'b0;
   end

   // Each level lasts two or three machine cycles, so two C4 samples see it
   task automatic edges(input int which, input int n, input logic slow);
      for (int i = 0; i < n; i++) begin
         pins[which] <= 1'b0;
         repeat (slow ? 12 : 8) @(posedge clk);
         pins[which] <= 1'b1;
         repeat (slow ? 12 : 8) @(posedge clk);
      end
   endtask

   // Gate levels, held until changed
   task automatic set_gates(input logic a, input logic b);
      gate_pin_a <= a;
      gate_pin_b <= b;
      @(posedge clk);
   endtask
endmodule // ttc_pin_model

/* test/ttc_properties.sv */
// Checker for the timer unit: bus answer, read data hold and flag timing.
// Assumes the unit's machine-cycle phase restarts at reset release.
`timescale 1ns/1ps

module ttc_properties (
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // Acknowledges and flags
   input wire logic vec_ack_a,
   input wire logic vec_ack_b,
   input wire logic ovf_a,
   input wire logic ovf_b,
   input wire logic irq_c
);
   logic [1:0] ph;
   logic wr_dp;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Phase mirror and write data phase; software may set or clear flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 2'h0;
         wr_dp <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         wr_dp <= hsel & htrans[1] & hready & hwrite;
      end
   end

   sequence s_no_xfer;
      !(hsel && htrans[1] && hready);
   endsequence
   sequence s_wr_taken;
      hsel && htrans[1] && hready && hwrite;
   endsequence
   sequence s_a_set;
      (!ovf_a && !wr_dp) ##1 ovf_a;
   endsequence
   sequence s_b_set;
      (!ovf_b && !wr_dp) ##1 ovf_b;
   endsequence

   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000) else $error("read data upper bits");
   a_rdata_hold: assert property (s_no_xfer |=> $stable(hrdata)) else $error("read data moved");
   a_wr_rdata_zero: assert property (s_wr_taken |=> hrdata == 32'h0000_0000)
      else $error("write left read data");
   a_ovfa_phase: assert property (s_a_set |-> ph == 2'h3)
      else $error("flag a set off phase three");
   a_ovfb_phase: assert property (s_b_set |-> ph == 2'h3)
      else $error("flag b set off phase three");
   a_ovfa_fall: assert property (ovf_a ##1 !ovf_a |-> $past(vec_ack_a) || $past(wr_dp))
      else $error("flag a dropped by itself");
   a_ovfb_fall: assert property (ovf_b ##1 !ovf_b |-> $past(vec_ack_b) || $past(wr_dp))
      else $error("flag b dropped by itself");
   a_irqc_fall: assert property (irq_c ##1 !irq_c |-> $past(wr_dp))
      else $error("counter c flag dropped by itself");
   a_veca_clear: assert property (vec_ack_a && ph != 2'h2 && !wr_dp |=> !ovf_a)
      else $error("vector ack did not clear flag a");
   a_reset_quiet: assert property ($rose(hresetn) |-> !ovf_a && !ovf_b && !irq_c)
      else $error("flags set after reset");
endmodule // ttc_properties

bind ttc_top ttc_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b),
   .ovf_a(ovf_a), .ovf_b(ovf_b), .irq_c(irq_c));
